// ==== rtl/pcsu_consts.vh ====
// pcsu_consts.vh: register map, field positions and event codes of the
// counter sampling unit. definitions only, included by the unit's modules.
`ifndef PCSU_CONSTS_VH
`define PCSU_CONSTS_VH

`define PCSU_CNT_BASE      12'h000
`define PCSU_ALIAS_BASE    12'h040
`define PCSU_SEL_BASE      12'h080
`define PCSU_SMP_EN_LO     12'h0a0
`define PCSU_SMP_EN_HI     12'h0a4
`define PCSU_CAP           12'h0b0
`define PCSU_OVF_STAT      12'h0b4
`define PCSU_REC_ADDR_LO   12'h0c0
`define PCSU_REC_ADDR_HI   12'h0c4
`define PCSU_REC_SRC       12'h0c8
`define PCSU_REC_LAT       12'h0cc
`define PCSU_REC_INFO      12'h0d0

`define PCSU_CNT_W         48
`define PCSU_CNT_RST       48'h0000_0000_0000
`define PCSU_SEL_RST       32'h0000_0000
`define PCSU_CAP_FW_BIT    13
`define PCSU_PS_EN_BIT     31
`define PCSU_STORE_CNT     2'h3
`define PCSU_PRECISE_RETIRE_DISTRIBUTION_CNT      2'h1

`define PCSU_SEL_EDGE_BIT  18
`define PCSU_SEL_ANY_BIT   21
`define PCSU_SEL_EN_BIT    22
`define PCSU_SEL_INV_BIT   23
`define PCSU_SEL_COUNT_THRESHOLD_MASK_HI  31
`define PCSU_SEL_COUNT_THRESHOLD_MASK_LO  24

`define PCSU_EV_INST       8'hc0
`define PCSU_EV_UOPS       8'hc2
`define PCSU_EV_BR         8'hc4
`define PCSU_EV_BR_MISP    8'hc5
`define PCSU_EV_MEM_TRANS  8'hcd
`define PCSU_EV_MEM_UOP    8'hd0
`define PCSU_EV_LD_HIT     8'hd1
`define PCSU_EV_LD_LLC     8'hd2
`define PCSU_EV_LD_MISC    8'hd4
`define PCSU_UM_LD_LAT     8'h01
`define PCSU_UM_ST         8'h02
`define PCSU_UM_PRECISE_RETIRE_DISTRIBUTION       8'h01

`endif

// ==== rtl/pcsu_evt_check.v ====
// pcsu_evt_check.v: decides whether one selector names a sampling event
// legal on a given sampling-capable counter. purely combinational.
`timescale 1ns/1ps
`include "pcsu_consts.vh"

module pcsu_evt_check (
  input  wire [31:0] sel_i,
  input  wire [1:0]  idx_i,
  input  wire        ps_en_i,
  output reg         valid_o,
  output wire        is_store_o,
  output wire        is_ld_lat_o
);
  wire [7:0] code;
  wire [7:0] um;
  wire       qual_clear;
  reg        known;

  assign code = sel_i[7:0];
  assign um   = sel_i[15:8];
  assign qual_clear = ~sel_i[`PCSU_SEL_EDGE_BIT] & ~sel_i[`PCSU_SEL_ANY_BIT] &
                      ~sel_i[`PCSU_SEL_INV_BIT] &
                      (sel_i[`PCSU_SEL_COUNT_THRESHOLD_MASK_HI:`PCSU_SEL_COUNT_THRESHOLD_MASK_LO] == 8'h00);

  assign is_store_o  = (code == `PCSU_EV_MEM_TRANS) && (um == `PCSU_UM_ST) &&
                       (idx_i == `PCSU_STORE_CNT) && ps_en_i;
  assign is_ld_lat_o = (code == `PCSU_EV_MEM_TRANS) && (um == `PCSU_UM_LD_LAT);

  always @* begin
    case (code)
      `PCSU_EV_INST:      known = (um == `PCSU_UM_PRECISE_RETIRE_DISTRIBUTION) && (idx_i == `PCSU_PRECISE_RETIRE_DISTRIBUTION_CNT);
      `PCSU_EV_UOPS:      known = (um == 8'h01) || (um == 8'h02);
      `PCSU_EV_BR:        known = (um == 8'h01) || (um == 8'h02) || (um == 8'h04) ||
                                  (um == 8'h08) || (um == 8'h10) || (um == 8'h20) ||
                                  (um == 8'h40);
      `PCSU_EV_BR_MISP:   known = (um == 8'h01) || (um == 8'h02) || (um == 8'h04) ||
                                  (um == 8'h10) || (um == 8'h20);
      `PCSU_EV_MEM_TRANS: known = is_ld_lat_o || is_store_o;
      `PCSU_EV_MEM_UOP:   known = (um == 8'h01) || (um == 8'h02) || (um == 8'h10) ||
                                  (um == 8'h20) || (um == 8'h40) || (um == 8'h80);
      `PCSU_EV_LD_HIT:    known = (um == 8'h01) || (um == 8'h02) || (um == 8'h04) ||
                                  (um == 8'h40);
      `PCSU_EV_LD_LLC:    known = (um == 8'h01) || (um == 8'h02) || (um == 8'h04) ||
                                  (um == 8'h08);
      `PCSU_EV_LD_MISC:   known = (um == 8'h02);
      default:            known = 1'b0;
    endcase
    valid_o = known & qual_clear;
  end
endmodule // pcsu_evt_check

// ==== rtl/pcsu_rec_build.v ====
// pcsu_rec_build.v: fills the three enhanced sample-record fields on a
// capture strobe; memory info arrives on the same clock as the unit.
`timescale 1ns/1ps
`include "pcsu_consts.vh"

module pcsu_rec_build (
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire        cap_i,
  input  wire        is_store_i,
  input  wire        is_ld_lat_i,
  input  wire [63:0] ld_addr_i,
  input  wire [3:0]  ld_src_i,
  input  wire        ld_stlb_miss_i,
  input  wire        ld_lock_i,
  input  wire [15:0] ld_lat_i,
  input  wire [63:0] st_addr_i,
  input  wire        st_dcu_hit_i,
  input  wire        st_stlb_miss_i,
  input  wire        st_lock_i,
  output reg  [63:0] addr_o,
  output reg  [63:0] src_o,
  output reg  [63:0] lat_o
);
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_o <= 64'h0;
      src_o  <= 64'h0;
      lat_o  <= 64'h0;
    end else if (cap_i) begin
      if (is_store_i) begin
        addr_o <= st_addr_i;
        src_o  <= {58'h0, st_lock_i, st_stlb_miss_i, 3'h0, st_dcu_hit_i};
        lat_o  <= 64'h0;
      end else begin
        addr_o <= ld_addr_i;
        // only the latency event carries source and latency data
        src_o  <= is_ld_lat_i ? {58'h0, ld_lock_i, ld_stlb_miss_i, ld_src_i}
                              : 64'h0;
        lat_o  <= is_ld_lat_i ? {48'h0, ld_lat_i} : 64'h0;
      end
    end
  end
endmodule // pcsu_rec_build

// ==== rtl/pcsu_top.v ====
// pcsu_top.v: general event counters with sign-extending and full-width
// writes, precise sampling on counters 0..3, and sample record capture.
// assumes an apb master on clk_i and event/memory strobes on the same clock.
//
// Summary of operation
// - a write to a counter's normal low word loads it sign-extended from bit 31.
// - every counter also has a full-width alias address pair.
// - the capability register reports full-width write support in bit 13.
// - only counters 0 to 3 can sample; counters 4 to 7 never make records.
// - bit 63 of the sampling enable lets counter 3 alone capture store info.
// - the retired-instruction distribution event, unit mask 01, is counter 1 only.
// - record address field holds the load source or store destination address.
// - record source field holds load source encoding for the latency event, the store status for store, else zero.
// - record latency field holds load latency for the latency event, or zero for every other record.
// - after a record, only overflowed and sampling-enabled status bits clear.
// - events C2, C4, C5 with their listed unit masks are sampling events.
// - events CD (01 latency, 02 store), D1 and D2 are sampling events.
`timescale 1ns/1ps
`include "pcsu_consts.vh"

module pcsu_top (
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire [7:0]  evt_inc_i,
  input  wire [63:0] ld_addr_i,
  input  wire [3:0]  ld_src_i,
  input  wire        ld_stlb_miss_i,
  input  wire        ld_lock_i,
  input  wire [15:0] ld_lat_i,
  input  wire [63:0] st_addr_i,
  input  wire        st_dcu_hit_i,
  input  wire        st_stlb_miss_i,
  input  wire        st_lock_i,
  output reg         rec_valid_o,
  output reg  [1:0]  rec_cnt_o,
  output wire [63:0] rec_addr_o,
  output wire [63:0] rec_src_o,
  output wire [63:0] rec_lat_o
);

  function [`PCSU_CNT_W-1:0] sext32;
    input [31:0] d;
    begin
      sext32 = {{(`PCSU_CNT_W-32){d[31]}}, d};
    end
  endfunction

  function cnt_hit;
    input [11:0] a;
    input [11:0] base;
    input [2:0]  idx;
    begin
      cnt_hit = (a[11:6] == base[11:6]) && (a[5:3] == idx) && (a[1:0] == 2'b00);
    end
  endfunction

  // selector window, word aligned; used by write strobe and read mux
  function sel_hit;
    input [11:0] a;
    begin
      sel_hit = (a[11:5] == (`PCSU_SEL_BASE >> 5)) && (a[1:0] == 2'b00);
    end
  endfunction

  // single-register write strobe
  function reg_wr;
    input        we;
    input [11:0] a;
    input [11:0] target;
    begin
      reg_wr = we && (a == target);
    end
  endfunction

  reg  [`PCSU_CNT_W-1:0] cnt_q [0:7];
  reg  [31:0]            sel_q [0:7];
  reg  [3:0]             smp_en_q;
  reg                    ps_en_q;
  reg  [7:0]             ovf_q;
  reg  [7:0]             ovf_d;
  reg  [3:0]             armed_q;
  reg  [3:0]             armed_d;
  reg                    store_rec_q;

  wire       wr_en;
  wire       rd_setup;
  reg        addr_hit;
  reg  [31:0] rdata_d;
  wire [7:0] inc;
  wire [7:0] ovf_set;
  wire [7:0] cnt_wr;
  wire [3:0] chk_valid;
  wire [3:0] chk_store;
  wire [3:0] chk_ld_lat;
  wire [3:0] elig;
  wire [3:0] trig;
  reg  [1:0] fire_idx;
  wire       fire;
  wire [3:0] fired;
  wire [7:0] hw_clr;
  wire [7:0] sw_clr;

  assign wr_en    = psel_i & penable_i & pwrite_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
  // every access completes in one access cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_hit;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_cnt
      wire nrm_lo = cnt_hit(paddr_i, `PCSU_CNT_BASE, g) & ~paddr_i[2];
      wire als_lo = cnt_hit(paddr_i, `PCSU_ALIAS_BASE, g) & ~paddr_i[2];
      wire als_hi = cnt_hit(paddr_i, `PCSU_ALIAS_BASE, g) & paddr_i[2];
      wire sel_wr = wr_en && sel_hit(paddr_i) && (paddr_i[4:2] == g);

      assign cnt_wr[g]  = wr_en & (nrm_lo | als_lo | als_hi);
      assign inc[g]     = evt_inc_i[g] & sel_q[g][`PCSU_SEL_EN_BIT];
      // a software write wins over a count in the same cycle
      assign ovf_set[g] = inc[g] & ~cnt_wr[g] & (&cnt_q[g]);

      always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          cnt_q[g] <= `PCSU_CNT_RST;
          sel_q[g] <= `PCSU_SEL_RST;
        end else begin
          if (wr_en & nrm_lo) begin
            cnt_q[g] <= sext32(pwdata_i);
          end else if (wr_en & als_lo) begin
            cnt_q[g] <= {cnt_q[g][`PCSU_CNT_W-1:32], pwdata_i};
          end else if (wr_en & als_hi) begin
            cnt_q[g] <= {pwdata_i[`PCSU_CNT_W-33:0], cnt_q[g][31:0]};
          end else if (inc[g]) begin
            cnt_q[g] <= cnt_q[g] + {{(`PCSU_CNT_W-1){1'b0}}, 1'b1};
          end
          if (sel_wr) begin
            sel_q[g] <= pwdata_i;
          end
        end
      end
    end

    for (g = 0; g < 4; g = g + 1) begin : g_smp
      localparam [1:0] CIDX = g;
      pcsu_evt_check u_chk (
        .sel_i       (sel_q[g]),
        .idx_i       (CIDX),
        .ps_en_i     (ps_en_q),
        .valid_o     (chk_valid[g]),
        .is_store_o  (chk_store[g]),
        .is_ld_lat_o (chk_ld_lat[g])
      );
    end
  endgenerate

  // counters 4..7 have no sampling path at all
  assign elig = smp_en_q & chk_valid;
  // overflow arms; the next counted event makes the record
  assign trig = armed_q & elig & inc[3:0];
  assign fire = |trig;

  always @* begin
    if (trig[0]) begin
      fire_idx = 2'h0;
    end else if (trig[1]) begin
      fire_idx = 2'h1;
    end else if (trig[2]) begin
      fire_idx = 2'h2;
    end else begin
      fire_idx = 2'h3;
    end
  end

  assign hw_clr = fire ? {4'h0, ovf_q[3:0] & smp_en_q} : 8'h00;
  assign sw_clr = reg_wr(wr_en, paddr_i, `PCSU_OVF_STAT) ? pwdata_i[7:0] : 8'h00;

  // only the counter that made the record disarms; a status clear by
  // software must not leave a counter armed forever, nor may a record on
  // one counter drop the arming of another
  assign fired = {3'h0, fire} << fire_idx;

  always @* begin
    // a fresh overflow wins over either clear
    ovf_d   = (ovf_q & ~hw_clr & ~sw_clr) | ovf_set;
    armed_d = ((armed_q & ~fired) | ovf_set[3:0]) & elig;
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      smp_en_q    <= 4'h0;
      ps_en_q     <= 1'b0;
      ovf_q       <= 8'h00;
      armed_q     <= 4'h0;
      rec_valid_o <= 1'b0;
      rec_cnt_o   <= 2'h0;
      store_rec_q <= 1'b0;
    end else begin
      ovf_q       <= ovf_d;
      armed_q     <= armed_d;
      rec_valid_o <= fire;
      if (fire) begin
        rec_cnt_o   <= fire_idx;
        store_rec_q <= chk_store[fire_idx];
      end
      if (reg_wr(wr_en, paddr_i, `PCSU_SMP_EN_LO)) begin
        smp_en_q <= pwdata_i[3:0];
      end
      if (reg_wr(wr_en, paddr_i, `PCSU_SMP_EN_HI)) begin
        ps_en_q <= pwdata_i[`PCSU_PS_EN_BIT];
      end
    end
  end

  pcsu_rec_build u_rec (
    .clk_i          (clk_i),
    .sys_rst_i      (sys_rst_i),
    .cap_i          (fire),
    .is_store_i     (chk_store[fire_idx]),
    .is_ld_lat_i    (chk_ld_lat[fire_idx]),
    .ld_addr_i      (ld_addr_i),
    .ld_src_i       (ld_src_i),
    .ld_stlb_miss_i (ld_stlb_miss_i),
    .ld_lock_i      (ld_lock_i),
    .ld_lat_i       (ld_lat_i),
    .st_addr_i      (st_addr_i),
    .st_dcu_hit_i   (st_dcu_hit_i),
    .st_stlb_miss_i (st_stlb_miss_i),
    .st_lock_i      (st_lock_i),
    .addr_o         (rec_addr_o),
    .src_o          (rec_src_o),
    .lat_o          (rec_lat_o)
  );

  // read mux and decode; counter high words read zero above bit 47
  always @* begin
    rdata_d  = 32'h0;
    addr_hit = 1'b1;
    if (paddr_i[11:7] == 5'h00 && paddr_i[1:0] == 2'b00) begin
      rdata_d = paddr_i[2] ? {{(64-`PCSU_CNT_W){1'b0}},
                              cnt_q[paddr_i[5:3]][`PCSU_CNT_W-1:32]}
                           : cnt_q[paddr_i[5:3]][31:0];
    end else if (sel_hit(paddr_i)) begin
      rdata_d = sel_q[paddr_i[4:2]];
    end else begin
      case (paddr_i)
        `PCSU_SMP_EN_LO:   rdata_d = {28'h0, smp_en_q};
        `PCSU_SMP_EN_HI:   rdata_d = {ps_en_q, 31'h0};
        `PCSU_CAP:         rdata_d = 32'h1 << `PCSU_CAP_FW_BIT;
        `PCSU_OVF_STAT:    rdata_d = {24'h0, ovf_q};
        `PCSU_REC_ADDR_LO: rdata_d = rec_addr_o[31:0];
        `PCSU_REC_ADDR_HI: rdata_d = rec_addr_o[63:32];
        `PCSU_REC_SRC:     rdata_d = rec_src_o[31:0];
        `PCSU_REC_LAT:     rdata_d = rec_lat_o[31:0];
        `PCSU_REC_INFO:    rdata_d = {23'h0, store_rec_q, 6'h0, rec_cnt_o};
        default: begin
          rdata_d  = 32'h0;
          addr_hit = 1'b0;
        end
      endcase
    end
  end

  // read data is taken in the setup cycle so it leaves a flop
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0;
    end else if (rd_setup) begin
      prdata_o <= rdata_d;
    end
  end

endmodule // pcsu_top

// ==== bench/pcsu_top_checker.sv ====
// pcsu_top_checker.sv: port-level assertions for the counter sampling unit.
// assumes one clk_i domain and the unit's constant header on the include path.
`timescale 1ns/1ps
`include "pcsu_consts.vh"

module pcsu_top_checker (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [7:0]  evt_inc_i,
  input wire logic [63:0] ld_addr_i,
  input wire logic [15:0] ld_lat_i,
  input wire logic [63:0] st_addr_i,
  input wire logic        rec_valid_o,
  input wire logic [1:0]  rec_cnt_o,
  input wire logic [63:0] rec_addr_o,
  input wire logic [63:0] rec_src_o,
  input wire logic [63:0] rec_lat_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_cap_rd;
    psel_i && !penable_i && !pwrite_i && paddr_i == `PCSU_CAP ##1 psel_i && penable_i;
  endsequence
  sequence s_rec;
    rec_valid_o;
  endsequence

  AST_CAP_FW: assert property (s_cap_rd |-> prdata_o[`PCSU_CAP_FW_BIT])
    else $error("capability read lacks full-width flag");
  AST_LOW_CNT: assert property (s_rec |-> ($past(evt_inc_i[3:0]) & (4'h1 << rec_cnt_o)) != 4'h0)
    else $error("record without an event on its counter");
  AST_REC_PULSE: assert property (s_rec |=> !rec_valid_o)
    else $error("record strobe longer than one cycle");
  AST_LOAD_ADDR: assert property (s_rec and rec_cnt_o != `PCSU_STORE_CNT |-> rec_addr_o == $past(ld_addr_i))
    else $error("load record address wrong");
  AST_SRC_RSV: assert property (s_rec |-> rec_src_o[63:6] == 58'h0)
    else $error("source field reserved bits set");
  AST_LAT_LOAD: assert property (s_rec and rec_lat_o != 64'h0 |->
    rec_lat_o == {48'h0, $past(ld_lat_i)} && rec_addr_o == $past(ld_addr_i))
    else $error("latency field not from a load");
  AST_STORE_LAT: assert property (s_rec and rec_cnt_o == `PCSU_STORE_CNT and
    rec_addr_o == $past(st_addr_i) |-> rec_lat_o == 64'h0)
    else $error("store record latency not zero");
  AST_FIELD_HOLD: assert property (!$stable(rec_addr_o) || !$stable(rec_lat_o) |-> rec_valid_o)
    else $error("record fields changed without strobe");
  AST_READY: assert property (psel_i && penable_i |-> pready_o)
    else $error("access phase without ready");
endmodule // pcsu_top_checker

bind pcsu_top pcsu_top_checker chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .evt_inc_i(evt_inc_i), .ld_addr_i(ld_addr_i),
  .ld_lat_i(ld_lat_i), .st_addr_i(st_addr_i), .rec_valid_o(rec_valid_o),
  .rec_cnt_o(rec_cnt_o), .rec_addr_o(rec_addr_o), .rec_src_o(rec_src_o), .rec_lat_o(rec_lat_o));

// ==== bench/tb_pcsu_top.sv ====
// tb_pcsu_top.sv: self-checking bench for the counter sampling unit.
// assumes the constant header on the include path and a zero-wait apb slave.
`timescale 1ns/1ps
`include "pcsu_consts.vh"

module tb_pcsu_top;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, rd_data;
  logic [7:0]  evt_inc_i = 8'h00;
  logic [63:0] ld_addr_i = 64'h0123_4567_89ab_cdef, st_addr_i = 64'hfeed_0000_0bad_f00c;
  logic [3:0]  ld_src_i = 4'h9;
  logic [15:0] ld_lat_i = 16'h00c7;
  logic        ld_stlb_miss_i = 1'b1, ld_lock_i = 1'b0, rd_err;
  logic        st_dcu_hit_i = 1'b1, st_stlb_miss_i = 1'b0, st_lock_i = 1'b1;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, rec_valid_o;
  wire  [1:0]  rec_cnt_o;
  wire  [63:0] rec_addr_o, rec_src_o, rec_lat_o;
  int          n_fail = 0, checks = 0;
  // one-hot masks of the listed events, {mask, code}
  logic [15:0] ev_ok [29] = '{16'h01c2, 16'h02c2, 16'h01c4, 16'h02c4, 16'h04c4, 16'h08c4,
    16'h10c4, 16'h20c4, 16'h40c4, 16'h01c5, 16'h02c5, 16'h04c5, 16'h10c5, 16'h20c5,
    16'h01d1, 16'h02d1, 16'h04d1, 16'h40d1, 16'h01d2, 16'h02d2, 16'h04d2, 16'h08d2,
    16'h01d0, 16'h02d0, 16'h10d0, 16'h20d0, 16'h40d0, 16'h80d0, 16'h02d4};

  pcsu_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .evt_inc_i(evt_inc_i), .ld_addr_i(ld_addr_i),
    .ld_src_i(ld_src_i), .ld_stlb_miss_i(ld_stlb_miss_i), .ld_lock_i(ld_lock_i),
    .ld_lat_i(ld_lat_i), .st_addr_i(st_addr_i), .st_dcu_hit_i(st_dcu_hit_i),
    .st_stlb_miss_i(st_stlb_miss_i), .st_lock_i(st_lock_i), .rec_valid_o(rec_valid_o),
    .rec_cnt_o(rec_cnt_o), .rec_addr_o(rec_addr_o), .rec_src_o(rec_src_o),
    .rec_lat_o(rec_lat_o));

  always #10 clk_i = ~clk_i;

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until ready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk_i);
    end
    if (n >= 16) n_fail++;
    rd_data = prdata_o;
    rd_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge clk_i);
    evt_inc_i <= m;
    @(posedge clk_i);
    evt_inc_i <= 8'h00;
  endtask

  task automatic arm(input int idx, input logic [15:0] ev, input logic [15:0] hi = 16'h0040);
    apb(1'b1, `PCSU_SEL_BASE + 12'(4 * idx), {hi, ev});
    apb(1'b1, `PCSU_ALIAS_BASE + 12'(8 * idx), 32'hffff_ffff);
    apb(1'b1, `PCSU_ALIAS_BASE + 12'(8 * idx + 4), 32'h0000_ffff);
  endtask

  // overflow, then one more event; judge record and status
  task automatic sample(input int idx, input logic [15:0] ev, input logic [31:0] en_lo,
      input logic [31:0] en_hi, input logic fire, input logic [63:0] ea,
      input logic [63:0] es, input logic [63:0] el, input logic [7:0] other,
      input logic [15:0] hi = 16'h0040);
    logic seen;
    seen = 1'b0;
    apb(1'b1, `PCSU_SMP_EN_LO, en_lo);
    apb(1'b1, `PCSU_SMP_EN_HI, en_hi);
    arm(idx, ev, hi);
    pulse(8'h01 << idx);
    pulse(8'h01 << idx);
    repeat (4) begin
      @(posedge clk_i);
      if (rec_valid_o === 1'b1 && !seen) begin
        seen = 1'b1;
        chk("record counter", 64'(idx), {62'h0, rec_cnt_o});
        chk("record address", ea, rec_addr_o);
        chk("record source", es, rec_src_o);
        chk("record latency", el, rec_lat_o);
      end
    end
    chk("record made", {63'h0, fire}, {63'h0, seen});
    apb(1'b0, `PCSU_OVF_STAT, 32'h0);
    chk("overflow status", {56'h0, other | (fire ? 8'h00 : 8'h01 << idx)}, {56'h0, rd_data[7:0]});
    apb(1'b1, `PCSU_OVF_STAT, 32'h0000_00ff);
  endtask

  task automatic t_regs();
    apb(1'b0, `PCSU_OVF_STAT, 32'h0);
    chk("status after reset", 64'h0, {32'h0, rd_data});
    apb(1'b0, `PCSU_CAP, 32'h0);
    chk("full-width flag", 64'h1, {63'h0, rd_data[13]});
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped error", 64'h1, {63'h0, rd_err});
    apb(1'b1, `PCSU_CNT_BASE + 12'h008, 32'h8000_0001);
    apb(1'b0, `PCSU_CNT_BASE + 12'h00c, 32'h0);
    chk("sign-extended high", 64'hffff, {32'h0, rd_data});
    apb(1'b1, `PCSU_CNT_BASE + 12'h008, 32'h7fff_ffff);
    apb(1'b0, `PCSU_CNT_BASE + 12'h00c, 32'h0);
    chk("positive high", 64'h0, {32'h0, rd_data});
    apb(1'b1, `PCSU_ALIAS_BASE + 12'h00c, 32'h0000_1234);
    apb(1'b1, `PCSU_ALIAS_BASE + 12'h008, 32'h8000_0003);
    apb(1'b0, `PCSU_CNT_BASE + 12'h00c, 32'h0);
    chk("alias high kept", 64'h1234, {32'h0, rd_data});
    apb(1'b0, `PCSU_ALIAS_BASE + 12'h008, 32'h0);
    chk("alias low", 64'h8000_0003, {32'h0, rd_data});
  endtask

  task automatic t_special();
    sample(2, 16'h01cd, 32'h4, 32'h0, 1'b1, ld_addr_i, 64'h19, 64'hc7, 8'h00);
    sample(3, 16'h02cd, 32'h8, 32'h8000_0000, 1'b1, st_addr_i, 64'h21, 64'h0, 8'h00);
    sample(3, 16'h02cd, 32'h8, 32'h0, 1'b0, 64'h0, 64'h0, 64'h0, 8'h00);
    sample(2, 16'h02cd, 32'h4, 32'h8000_0000, 1'b0, 64'h0, 64'h0, 64'h0, 8'h00);
    sample(1, 16'h01c0, 32'h2, 32'h0, 1'b1, ld_addr_i, 64'h0, 64'h0, 8'h00);
    sample(0, 16'h01c0, 32'h1, 32'h0, 1'b0, 64'h0, 64'h0, 64'h0, 8'h00);
    sample(4, 16'h01c2, 32'hf, 32'h0, 1'b0, 64'h0, 64'h0, 64'h0, 8'h00);
    sample(0, 16'h08c5, 32'h1, 32'h0, 1'b0, 64'h0, 64'h0, 64'h0, 8'h00);
    sample(0, 16'h80c4, 32'h1, 32'h0, 1'b0, 64'h0, 64'h0, 64'h0, 8'h00);
    sample(0, 16'h01c2, 32'h1, 32'h0, 1'b0, 64'h0, 64'h0, 64'h0, 8'h00, 16'h0044);
    sample(0, 16'h01c2, 32'h1, 32'h0, 1'b0, 64'h0, 64'h0, 64'h0, 8'h00, 16'h0060);
    sample(0, 16'h01c2, 32'h1, 32'h0, 1'b0, 64'h0, 64'h0, 64'h0, 8'h00, 16'h00c0);
    sample(0, 16'h01c2, 32'h1, 32'h0, 1'b0, 64'h0, 64'h0, 64'h0, 8'h00, 16'h0140);
  endtask

  // counters 2 and 5 overflow without sampling; their status must survive
  task automatic t_keep();
    arm(2, 16'h01c2);
    arm(5, 16'h01c2);
    pulse(8'h24);
    sample(0, 16'h01c2, 32'h1, 32'h0, 1'b1, ld_addr_i, 64'h0, 64'h0, 8'h24);
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    foreach (ev_ok[i]) sample(0, ev_ok[i], 32'h1, 32'h0, 1'b1, ld_addr_i, 64'h0, 64'h0, 8'h00);
    t_special();
    t_keep();
    results();
  end

  initial begin
    #400000;
    n_fail++;
    results();
  end
endmodule // tb_pcsu_top
